// File: rtl/tfx_extractor.sv
/*
 * read side of the transmit fifo: takes buffers of two command words plus
 * payload, checks them, strips the commands and forwards frame words with
 * byte enables to the mac transmit interface.
 * assumes the fifo read port and mac port run on clk_i; fifo data are
 * valid while fifo_valid_i is high and popped when fifo_ready_o is high.
 */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tfx_consts.svh"

module tfx_extractor
	import tfx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// transmit fifo read port
	input wire logic [31:0] fifo_data_i,
	input wire logic fifo_valid_i,
	output logic fifo_ready_o,
	// mac transmit interface
	output logic [31:0] mac_data_o,
	output logic [3:0] mac_be_o,
	output logic mac_first_o,
	output logic mac_last_o,
	output logic mac_valid_o,
	input wire logic mac_ready_i,
	output logic mac_no_crc_o,
	output logic mac_no_pad_o,
	output logic mac_csum_o,
	// per frame status back from the mac
	input wire logic [31:0] mac_status_i,
	input wire logic mac_status_valid_i,
	output logic status_pulse_o,
	// usb side
	output logic tx_error_o,
	output logic bulk_out_stall_o,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o
);

	tfx_state_t state_q;
	tfx_state_t state_d;

	// current buffer
	logic [31:0] cmda_q;
	logic [9:0] word_idx_q;
	logic [9:0] word_cnt_q;
	logic buf_last_q;
	logic first_word_q;

	// current frame
	logic in_frame_q;
	logic [31:0] ref_cmdb_q;
	logic [11:0] accum_q;

	// output stage
	logic [31:0] out_data_q;
	logic [3:0] out_be_q;
	logic out_first_q;
	logic out_last_q;
	logic out_valid_q;
	logic no_crc_q;
	logic no_pad_q;
	logic csum_q;

	// sticky halt, only reset leaves it
	logic halt_q;
	logic status_pulse_q;

	// decoded command fields
	logic [1:0] cur_ofs_w;
	logic cur_fs_w;
	logic cur_ls_w;
	logic [10:0] cur_size_w;
	logic [10:0] frame_len_w;
	logic [11:0] acc_next_w;
	logic [11:0] span_w;
	tfx_cause_t cause_w;
	logic err_w;

	logic out_free_w;
	logic pop_w;
	logic data_pop_w;
	logic cmdb_pop_w;
	logic [3:0] lane_be_w;

	logic csum_en_w;
	logic stall_dis_w;
	logic err_flag_w;

	assign cur_ofs_w = cmda_q[`TFX_CMDA_OFS_HI:`TFX_CMDA_OFS_LO];
	assign cur_fs_w = cmda_q[`TFX_CMDA_FIRST];
	assign cur_ls_w = cmda_q[`TFX_CMDA_LAST];
	assign cur_size_w = cmda_q[`TFX_SIZE_HI:`TFX_SIZE_LO];
	assign frame_len_w = fifo_data_i[`TFX_SIZE_HI:`TFX_SIZE_LO];

	// running size sum: restarts on a frame opener
	assign acc_next_w = in_frame_q ? (accum_q + {1'b0, cur_size_w}) : {1'b0, cur_size_w};

	// bytes this buffer spans after the two command words, plus 3 so bits 11:2 give its word count
	assign span_w = {10'h000, cur_ofs_w} + {1'b0, cur_size_w} + 12'h003;

	// buffer checks, evaluated as command b leaves the fifo
	always_comb begin
		cause_w = '0;
		if (in_frame_q) begin
			if (((fifo_data_i ^ ref_cmdb_q) & `TFX_CMDB_CMP_MASK) != 32'h0000_0000) begin
				cause_w[`TFX_CAUSE_CMDB] = 1'b1;
			end
			if (cur_fs_w) begin
				cause_w[`TFX_CAUSE_EXTRA_FS] = 1'b1;
			end
		end else if (!cur_fs_w) begin
			cause_w[`TFX_CAUSE_NO_FS] = 1'b1;
		end
		if ((acc_next_w >= {1'b0, frame_len_w}) && !cur_ls_w) begin
			cause_w[`TFX_CAUSE_NO_LS] = 1'b1;
		end
		if (cur_ls_w && (acc_next_w < {1'b0, frame_len_w})) begin
			cause_w[`TFX_CAUSE_EARLY_LS] = 1'b1;
		end
		// zero size and a final sum mismatch share one cause bit
		if (cur_size_w == 11'h000) begin
			cause_w[`TFX_CAUSE_ZERO] = 1'b1;
		end
		if (cur_ls_w && (acc_next_w != {1'b0, frame_len_w})) begin
			cause_w[`TFX_CAUSE_SUM] = 1'b1;
		end
	end

	assign err_w = cmdb_pop_w && (cause_w != '0);

	// output stage takes a word when empty or being drained
	assign out_free_w = !out_valid_q || mac_ready_i;

	// commands are always swallowed outside the halt state; payload only when the mac keeps up
	always_comb begin
		case (state_q)
			TFX_CMD_A: fifo_ready_o = 1'b1;
			TFX_CMD_B: fifo_ready_o = 1'b1;
			TFX_DATA: fifo_ready_o = out_free_w;
			default: fifo_ready_o = 1'b0;
		endcase
	end

	assign pop_w = fifo_ready_o && fifo_valid_i;
	assign cmdb_pop_w = pop_w && (state_q == TFX_CMD_B);
	assign data_pop_w = pop_w && (state_q == TFX_DATA);

	always_comb begin
		state_d = state_q;
		case (state_q)
			TFX_CMD_A: begin
				if (pop_w) begin
					state_d = TFX_CMD_B;
				end
			end
			TFX_CMD_B: begin
				if (err_w) begin
					state_d = TFX_HALT;
				end else if (pop_w) begin
					state_d = TFX_DATA;
				end
			end
			TFX_DATA: begin
				if (data_pop_w && (word_idx_q == word_cnt_q - 10'h001)) begin
					state_d = TFX_CMD_A;
				end
			end
			default: state_d = TFX_HALT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= TFX_CMD_A;
		end else begin
			state_q <= state_d;
		end
	end

	// command a kept for the rest of the buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmda_q <= 32'h0000_0000;
		end else if (pop_w && (state_q == TFX_CMD_A)) begin
			cmda_q <= fifo_data_i;
		end
	end

	// buffer word walk; length from size and offset, commands dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_idx_q <= 10'h000;
			word_cnt_q <= 10'h000;
			buf_last_q <= 1'b0;
		end else if (cmdb_pop_w) begin
			word_idx_q <= 10'h000;
			word_cnt_q <= span_w[11:2];
			buf_last_q <= cur_ls_w;
		end else if (data_pop_w) begin
			word_idx_q <= word_idx_q + 10'h001;
		end
	end

	// frame bookkeeping and the reference command b
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_frame_q <= 1'b0;
			ref_cmdb_q <= 32'h0000_0000;
			accum_q <= 12'h000;
		end else if (cmdb_pop_w && !err_w) begin
			in_frame_q <= !cur_ls_w;
			accum_q <= acc_next_w;
			if (!in_frame_q) begin
				ref_cmdb_q <= fifo_data_i;
			end
		end
	end

	// frame attributes latched from the opening buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			no_crc_q <= 1'b0;
			no_pad_q <= 1'b0;
			csum_q <= 1'b0;
			first_word_q <= 1'b0;
		end else if (cmdb_pop_w && !err_w && !in_frame_q) begin
			// padding disabled forces the crc back on
			no_crc_q <= fifo_data_i[`TFX_CMDB_NO_CRC] && !fifo_data_i[`TFX_CMDB_NO_PAD];
			no_pad_q <= fifo_data_i[`TFX_CMDB_NO_PAD];
			csum_q <= fifo_data_i[`TFX_CMDB_CSUM] && cur_fs_w && csum_en_w;
			first_word_q <= 1'b1;
		end else if (data_pop_w) begin
			first_word_q <= 1'b0;
		end
	end

	tfx_lane_mask u_lane_mask (
		.word_idx_i(word_idx_q),
		.first_byte_lane_i(cur_ofs_w),
		.byte_count_i(cur_size_w),
		.byte_en_o(lane_be_w)
	);

	// registered output word; last marks the end of the frame length
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_data_q <= 32'h0000_0000;
			out_be_q <= 4'h0;
			out_first_q <= 1'b0;
			out_last_q <= 1'b0;
			out_valid_q <= 1'b0;
		end else if (data_pop_w) begin
			out_data_q <= fifo_data_i;
			out_be_q <= lane_be_w;
			out_first_q <= first_word_q;
			out_last_q <= buf_last_q && (word_idx_q == word_cnt_q - 10'h001);
			out_valid_q <= 1'b1;
		end else if (mac_ready_i) begin
			out_valid_q <= 1'b0;
		end
	end

	// latched here so a later register clear cannot resume the path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_q <= 1'b0;
		end else if (err_w) begin
			halt_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_pulse_q <= 1'b0;
		end else begin
			status_pulse_q <= mac_status_valid_i;
		end
	end

	tfx_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o),
		.err_event_i(err_w),
		.err_cause_i(cause_w),
		.mac_status_i(mac_status_i),
		.mac_status_valid_i(mac_status_valid_i),
		.csum_engine_en_o(csum_en_w),
		.stall_disable_o(stall_dis_w),
		.tx_error_flag_o(err_flag_w)
	);

	assign mac_data_o = out_data_q;
	assign mac_be_o = out_be_q;
	assign mac_first_o = out_first_q;
	assign mac_last_o = out_last_q;
	assign mac_valid_o = out_valid_q;
	assign mac_no_crc_o = no_crc_q;
	assign mac_no_pad_o = no_pad_q;
	assign mac_csum_o = csum_q;
	assign status_pulse_o = status_pulse_q;
	assign tx_error_o = err_flag_w;
	// stall holds for the life of the halt unless the stall disable control bit is set, independent of the flag
	assign bulk_out_stall_o = halt_q && !stall_dis_w;

endmodule // tfx_extractor

`default_nettype wire

// File: rtl/tfx_consts.svh
/*
 * shared constants of the transmit frame extractor: command word fields,
 * register offsets and field positions, reset values.
 * assumes nothing; definitions only, included by bare name.
 */
`ifndef TFX_CONSTS_SVH
`define TFX_CONSTS_SVH

// command a fields
`define TFX_CMDA_OFS_HI 17
`define TFX_CMDA_OFS_LO 16
`define TFX_CMDA_FIRST 13
`define TFX_CMDA_LAST 12
`define TFX_SIZE_HI 10
`define TFX_SIZE_LO 0

// command b fields
`define TFX_CMDB_CSUM 14
`define TFX_CMDB_NO_CRC 13
`define TFX_CMDB_NO_PAD 12
// compare mask: every bit except the checksum request
`define TFX_CMDB_CMP_MASK 32'hffff_bfff

// mac status word error summary bit
`define TFX_STAT_ERR 15

// register offsets (byte addresses)
`define TFX_REG_CTRL 8'h00
`define TFX_REG_STATUS 8'h04
`define TFX_REG_TXSTAT 8'h08
`define TFX_REG_FRAMES 8'h0c
`define TFX_REG_FRMERR 8'h10

// control register fields
`define TFX_CTRL_CSUM_EN 0
`define TFX_CTRL_STALL_DIS 1
`define TFX_CTRL_RESET 2'h0

// status register fields: bit 0 summary flag, bits 6:1 cause
`define TFX_STS_ERR 0
`define TFX_STS_CAUSE_LO 1
`define TFX_STS_CAUSE_HI 6

// cause vector positions
`define TFX_CAUSE_CMDB 0
`define TFX_CAUSE_NO_FS 1
`define TFX_CAUSE_EXTRA_FS 2
`define TFX_CAUSE_NO_LS 3
`define TFX_CAUSE_EARLY_LS 4
`define TFX_CAUSE_ZERO 5
`define TFX_CAUSE_SUM 5

`endif

// File: rtl/tfx_pkg.sv
/*
 * types of the transmit frame extractor.
 * assumes tfx_consts.svh for numeric constants.
 */
package tfx_pkg;

	typedef enum logic [1:0] {
		TFX_CMD_A,
		TFX_CMD_B,
		TFX_DATA,
		TFX_HALT
	} tfx_state_t;

	typedef logic [5:0] tfx_cause_t;

endpackage

// File: rtl/tfx_lane_mask.sv
/*
 * byte enables of one data word of a buffer, from its word index,
 * first byte lane and payload byte count.
 * assumes count is nonzero and index lies within the buffer.
 */
`timescale 1ns/1ps
`default_nettype none

module tfx_lane_mask
	import tfx_pkg::*;
(
	input wire logic [9:0] word_idx_i,
	input wire logic [1:0] first_byte_lane_i,
	input wire logic [10:0] byte_count_i,
	output logic [3:0] byte_en_o
);

	logic [11:0] start_w;
	logic [11:0] end_w;

	assign start_w = {10'h000, first_byte_lane_i};
	assign end_w = 12'({1'b0, byte_count_i}) + start_w;

	// a lane is live only between the start offset and the buffer end
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			logic [11:0] pos_w;
			assign pos_w = {word_idx_i, 2'(lane)};
			assign byte_en_o[lane] = (pos_w >= start_w) && (pos_w < end_w);
		end
	endgenerate

endmodule // tfx_lane_mask

`default_nettype wire

// File: rtl/tfx_regs.sv
/*
 * register port of the transmit frame extractor: control bits,
 * sticky error flag with cause, last mac status word and counters.
 * assumes one-cycle strobes, never both at once, from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tfx_consts.svh"

module tfx_regs
	import tfx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire logic err_event_i,
	input wire tfx_cause_t err_cause_i,
	input wire logic [31:0] mac_status_i,
	input wire logic mac_status_valid_i,
	output logic csum_engine_en_o,
	output logic stall_disable_o,
	output logic tx_error_flag_o
);

	logic [1:0] ctrl_q;
	logic err_q;
	tfx_cause_t cause_q;
	logic [31:0] txstat_q;
	logic [15:0] frames_q;
	logic [15:0] frmerr_q;
	logic [31:0] rdata_q;
	logic clr_w;

	assign clr_w = reg_we_i && (reg_addr_i == `TFX_REG_STATUS) && reg_wdata_i[`TFX_STS_ERR];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `TFX_CTRL_RESET;
		end else if (reg_we_i && (reg_addr_i == `TFX_REG_CTRL)) begin
			ctrl_q <= reg_wdata_i[1:0];
		end
	end

	// write one clears; a new error in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_q <= 1'b0;
			cause_q <= '0;
		end else if (err_event_i) begin
			err_q <= 1'b1;
			cause_q <= cause_q | err_cause_i;
		end else if (clr_w) begin
			err_q <= 1'b0;
			cause_q <= '0;
		end
	end

	// status word feeds statistics
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txstat_q <= 32'h0000_0000;
			frames_q <= 16'h0000;
			frmerr_q <= 16'h0000;
		end else if (mac_status_valid_i) begin
			txstat_q <= mac_status_i;
			frames_q <= frames_q + 16'h0001;
			if (mac_status_i[`TFX_STAT_ERR]) begin
				frmerr_q <= frmerr_q + 16'h0001;
			end
		end
	end

	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i || !reg_re_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_addr_i == `TFX_REG_CTRL) begin
			rdata_q <= {30'h0000_0000, ctrl_q};
		end else if (reg_addr_i == `TFX_REG_STATUS) begin
			rdata_q <= {25'h000_0000, cause_q, err_q};
		end else if (reg_addr_i == `TFX_REG_TXSTAT) begin
			rdata_q <= txstat_q;
		end else if (reg_addr_i == `TFX_REG_FRAMES) begin
			rdata_q <= {16'h0000, frames_q};
		end else if (reg_addr_i == `TFX_REG_FRMERR) begin
			rdata_q <= {16'h0000, frmerr_q};
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign csum_engine_en_o = ctrl_q[`TFX_CTRL_CSUM_EN];
	assign stall_disable_o = ctrl_q[`TFX_CTRL_STALL_DIS];
	assign tx_error_flag_o = err_q;

endmodule // tfx_regs

`default_nettype wire

// File: bench/tfx_checker_assertions.sv
/* port checker of the frame extractor.
   assumes one clock, synchronous active high reset; bound below. */
`timescale 1ns/1ps
`default_nettype none
module tfx_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fifo_ready_o,
	input wire logic [31:0] mac_data_o,
	input wire logic [3:0] mac_be_o,
	input wire logic mac_first_o,
	input wire logic mac_last_o,
	input wire logic mac_valid_o,
	input wire logic mac_ready_i,
	input wire logic mac_no_crc_o,
	input wire logic mac_no_pad_o,
	input wire logic mac_csum_o,
	input wire logic mac_status_valid_i,
	input wire logic status_pulse_o,
	input wire logic tx_error_o,
	input wire logic bulk_out_stall_o,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [31:0] reg_rdata_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_halt; tx_error_o |-> !fifo_ready_o; endproperty
	a_halt: assert property (p_halt) else $error("pop while halted");
	property p_drain; tx_error_o && !mac_valid_o |=> !mac_valid_o; endproperty
	a_drain: assert property (p_drain) else $error("word sent after error");
	property p_stall; bulk_out_stall_o |-> !fifo_ready_o; endproperty
	a_stall: assert property (p_stall) else $error("stall without halt");
	property p_unstall; $fell(bulk_out_stall_o) |-> $past(reg_we_i); endproperty
	a_unstall: assert property (p_unstall) else $error("stall dropped by itself");
	property p_hold;
		mac_valid_o && !mac_ready_i |=> mac_valid_o && $stable(mac_data_o) && $stable(mac_be_o) && $stable(mac_last_o);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed while stalled");
	property p_be; mac_valid_o |-> mac_be_o != 4'h0; endproperty
	a_be: assert property (p_be) else $error("empty word sent");
	property p_next; mac_valid_o && mac_ready_i && mac_last_o |=> !mac_valid_o || mac_first_o; endproperty
	a_next: assert property (p_next) else $error("frame not opened after last");
	property p_attr;
		mac_valid_o && !mac_first_o && !mac_last_o |-> $stable(mac_no_crc_o) && $stable(mac_no_pad_o) && $stable(mac_csum_o);
	endproperty
	a_attr: assert property (p_attr) else $error("attributes moved in frame");
	property p_excl; !(mac_no_crc_o && mac_no_pad_o); endproperty
	a_excl: assert property (p_excl) else $error("crc dropped with padding off");
	property p_pulse; mac_status_valid_i |=> status_pulse_o; endproperty
	a_pulse: assert property (p_pulse) else $error("status not signalled");
	property p_cause; status_pulse_o |-> $past(mac_status_valid_i); endproperty
	a_cause: assert property (p_cause) else $error("status pulse uncaused");
	property p_rdata; !$past(reg_re_i) |-> reg_rdata_o == 32'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
	c_err: cover property ($rose(tx_error_o));
	c_last: cover property (mac_valid_o && mac_ready_i && mac_last_o);
	c_stat: cover property (status_pulse_o);
endmodule // tfx_checker
bind tfx_extractor tfx_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .fifo_ready_o(fifo_ready_o),
	.mac_data_o(mac_data_o), .mac_be_o(mac_be_o), .mac_first_o(mac_first_o), .mac_last_o(mac_last_o),
	.mac_valid_o(mac_valid_o), .mac_ready_i(mac_ready_i), .mac_no_crc_o(mac_no_crc_o),
	.mac_no_pad_o(mac_no_pad_o), .mac_csum_o(mac_csum_o), .mac_status_valid_i(mac_status_valid_i),
	.status_pulse_o(status_pulse_o), .tx_error_o(tx_error_o), .bulk_out_stall_o(bulk_out_stall_o),
	.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// File: bench/tfx_mac_model.sv
/* mac transmit side: takes words, returns one status word per frame.
   assumes the extractor's valid/ready handshake on clk_i. */
`timescale 1ns/1ps
`default_nettype none
module tfx_mac_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mac_valid_i,
	input wire logic mac_last_i,
	input wire logic slow_i,
	input wire logic [31:0] status_word_i,
	output logic mac_ready_o = 1'b0,
	output logic status_valid_o = 1'b0,
	output logic [31:0] status_o = 32'h0
);
	logic [1:0] wait_q = 2'h0;
	always @(posedge clk_i) begin
		if (rst_i) begin
			mac_ready_o <= 1'b0;
			status_valid_o <= 1'b0;
			wait_q <= 2'h0;
		end else begin
			// slow mode stalls every other cycle
			mac_ready_o <= slow_i ? !mac_ready_o : 1'b1;
			status_valid_o <= 1'b0;
			status_o <= ~status_word_i;
			if (mac_valid_i && mac_ready_o && mac_last_i)
				wait_q <= 2'h3;
			else if (wait_q != 2'h0)
				wait_q <= wait_q - 2'h1;
			if (wait_q == 2'h1) begin
				status_valid_o <= 1'b1;
				status_o <= status_word_i;
			end
		end
	end
endmodule // tfx_mac_model
`default_nettype wire

// File: bench/tx_frame_extractor_bench.sv
/* self-checking bench of the frame extractor.
   assumes the mac model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "tfx_consts.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module tx_frame_extractor_bench
	import tfx_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, fifo_valid_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0, slow = 1'b0;
	logic [31:0] fifo_data_i = 32'h0, reg_wdata_i = 32'h0, stat_word = 32'h0, mac_data_o, mac_status_i, reg_rdata_o;
	logic [7:0] reg_addr_i = 8'h0;
	logic [3:0] mac_be_o;
	logic fifo_ready_o, mac_first_o, mac_last_o, mac_valid_o, mac_ready_i, mac_no_crc_o, mac_no_pad_o;
	logic mac_csum_o, mac_status_valid_i, status_pulse_o, tx_error_o, bulk_out_stall_o;
	int compares = 0, miscompares = 0, cycles = 0, npulse = 0;
	logic [40:0] mq[$];
	tfx_extractor i_dut (.clk_i(clk_i), .rst_i(rst_i), .fifo_data_i(fifo_data_i), .fifo_valid_i(fifo_valid_i),
		.fifo_ready_o(fifo_ready_o), .mac_data_o(mac_data_o), .mac_be_o(mac_be_o), .mac_first_o(mac_first_o),
		.mac_last_o(mac_last_o), .mac_valid_o(mac_valid_o), .mac_ready_i(mac_ready_i), .mac_no_crc_o(mac_no_crc_o),
		.mac_no_pad_o(mac_no_pad_o), .mac_csum_o(mac_csum_o), .mac_status_i(mac_status_i),
		.mac_status_valid_i(mac_status_valid_i), .status_pulse_o(status_pulse_o), .tx_error_o(tx_error_o),
		.bulk_out_stall_o(bulk_out_stall_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));
	tfx_mac_model i_mac (.clk_i(clk_i), .rst_i(rst_i), .mac_valid_i(mac_valid_o), .mac_last_i(mac_last_o),
		.slow_i(slow), .status_word_i(stat_word), .mac_ready_o(mac_ready_i), .status_valid_o(mac_status_valid_i),
		.status_o(mac_status_i));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (mac_valid_o === 1'b1 && mac_ready_i === 1'b1)
			mq.push_back({mac_no_crc_o, mac_no_pad_o, mac_csum_o, mac_first_o, mac_last_o, mac_be_o, mac_data_o});
		if (status_pulse_o === 1'b1)
			npulse++;
		// ceiling well above the few hundred cycles the tests need
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task reset_dut(input int n);
		mq.delete();
		npulse = 0;
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
		@(posedge clk_i);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK("register", e, d)
	endtask
	task push(input logic [31:0] w);
		int n;
		n = 0;
		fifo_data_i <= w;
		fifo_valid_i <= 1'b1;
		@(negedge clk_i);
		while (fifo_ready_o !== 1'b1 && n < 100) begin
			n++;
			@(negedge clk_i);
		end
		if (n == 100) begin
			miscompares++;
			$display("mismatch fifo_ready expected 1 seen 0");
		end
		@(posedge clk_i);
	endtask
	task send_buf(input int ofs, size, input logic fs, ls, input logic [31:0] b);
		push({14'h0, 2'(ofs), 2'h0, fs, ls, 1'b0, 11'(size)});
		push(b);
		for (int k = 0; k < (ofs + size + 3) / 4; k++)
			push(32'h11111111 * (k + 1));
	endtask
	task chk_buf(input int ofs, size, input logic fb, lb, input logic [2:0] at);
		logic [40:0] g;
		logic [3:0] be;
		logic [31:0] m;
		int n, w;
		n = (ofs + size + 3) / 4;
		for (int k = 0; k < n; k++) begin
			w = 0;
			while (mq.size() == 0 && w < 100) begin
				w++;
				@(posedge clk_i);
			end
			g = mq.pop_front();
			for (int l = 0; l < 4; l++) begin
				be[l] = (4 * k + l >= ofs) && (4 * k + l < ofs + size);
				m[8 * l +: 8] = {8{be[l]}};
			end
			`CHK("byte_en", be, g[35:32])
			`CHK("data", (32'h11111111 * (k + 1)) & m, g[31:0] & m)
			`CHK("first", fb && k == 0, g[37])
			`CHK("last", lb && k == n - 1, g[36])
			if (k == 0 && fb)
				`CHK("attr", at, g[40:38])
		end
	endtask
	task wait_pulse(input int n);
		int w;
		w = 0;
		while (npulse < n && w < 200) begin
			w++;
			@(posedge clk_i);
		end
		`CHK("pulses", n, npulse)
	endtask
	task t_single;
		rchk(`TFX_REG_CTRL, 32'h0);
		rchk(`TFX_REG_STATUS, 32'h0);
		stat_word <= 32'h00008102;
		// checksum asked with engine off must not reach the mac
		send_buf(2, 3, 1'b1, 1'b1, 32'h00006003);
		fifo_valid_i <= 1'b0;
		chk_buf(2, 3, 1'b1, 1'b1, 3'b100);
		wait_pulse(1);
		rchk(`TFX_REG_TXSTAT, 32'h00008102);
		rchk(`TFX_REG_FRAMES, 32'h1);
		rchk(`TFX_REG_FRMERR, 32'h1);
		$display("test single done");
	endtask
	task t_multi;
		wr(`TFX_REG_CTRL, 32'h1);
		rchk(`TFX_REG_CTRL, 32'h1);
		rchk(8'h20, 32'h0);
		slow <= 1'b1;
		stat_word <= 32'h00000048;
		send_buf(3, 5, 1'b1, 1'b0, 32'h0000700b);
		send_buf(0, 4, 1'b0, 1'b0, 32'h0000300b);
		send_buf(1, 2, 1'b0, 1'b1, 32'h0000300b);
		fifo_valid_i <= 1'b0;
		chk_buf(3, 5, 1'b1, 1'b0, 3'b011);
		chk_buf(0, 4, 1'b0, 1'b0, 3'b000);
		chk_buf(1, 2, 1'b0, 1'b1, 3'b000);
		// pulse count runs on from the single test, so this frame is the second
		wait_pulse(2);
		`CHK("tx_error", 1'b0, tx_error_o)
		wr(`TFX_REG_TXSTAT, 32'hffffffff);
		rchk(`TFX_REG_TXSTAT, 32'h00000048);
		rchk(`TFX_REG_FRAMES, 32'h2);
		rchk(`TFX_REG_FRMERR, 32'h1);
		slow <= 1'b0;
		$display("test multi done");
	endtask
	task err_case(input int len, input logic ls1, fs2, ls2, input int sz2, input logic [31:0] bx, input int cause);
		logic [31:0] d, e;
		e = 32'h1 | (32'h1 << (cause + 1));
		reset_dut(2);
		send_buf(0, 4, 1'b1, ls1, 32'(len));
		push({18'h0, fs2, ls2, 1'b0, 11'(sz2)});
		push(32'(len) ^ bx);
		fifo_valid_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		`CHK("tx_error", 1'b1, tx_error_o)
		`CHK("fifo_ready", 1'b0, fifo_ready_o)
		`CHK("stall", 1'b1, bulk_out_stall_o)
		@(posedge clk_i);
		rd(`TFX_REG_STATUS, d);
		`CHK("cause", e, d & e)
		wr(`TFX_REG_CTRL, 32'h2);
		@(negedge clk_i);
		`CHK("stall", 1'b0, bulk_out_stall_o)
		@(posedge clk_i);
		wr(`TFX_REG_STATUS, 32'h1);
		rchk(`TFX_REG_STATUS, 32'h0);
		`CHK("fifo_ready", 1'b0, fifo_ready_o)
		$display("test error cause %0d done", cause);
	endtask
	initial begin
		reset_dut(20);
		t_single;
		t_multi;
		err_case(8, 1'b0, 1'b0, 1'b1, 4, 32'h2000, `TFX_CAUSE_CMDB);
		err_case(4, 1'b1, 1'b0, 1'b1, 4, 32'h0, `TFX_CAUSE_NO_FS);
		err_case(8, 1'b0, 1'b1, 1'b1, 4, 32'h0, `TFX_CAUSE_EXTRA_FS);
		err_case(8, 1'b0, 1'b0, 1'b0, 4, 32'h0, `TFX_CAUSE_NO_LS);
		err_case(12, 1'b0, 1'b0, 1'b1, 4, 32'h0, `TFX_CAUSE_EARLY_LS);
		err_case(8, 1'b0, 1'b0, 1'b1, 0, 32'h0, `TFX_CAUSE_ZERO);
		err_case(8, 1'b0, 1'b0, 1'b1, 6, 32'h0, `TFX_CAUSE_SUM);
		end_of_test();
	end
endmodule // tx_frame_extractor_bench
`default_nettype wire
